// ### common/sat_consts.svh
// Constants for the stereo serial audio transmitter
`ifndef SAT_CONSTS_SVH
`define SAT_CONSTS_SVH

// System clock rate in Hz (10 ns period)
`define SAT_CLK_HZ          100000000
// Sample rate in Hz and bit cells per stereo frame
`define SAT_SAMPLE_HZ       12000
`define SAT_FRAME_BITS      32
// Half bit-clock period in system clocks, integer division only
`define SAT_HALF_DIV        (`SAT_CLK_HZ / (`SAT_SAMPLE_HZ * `SAT_FRAME_BITS * 2))
// Default channel word length and FIFO depth
`define SAT_WORD_BITS       16
`define SAT_FIFO_DEPTH      16
// Bit index of the byte MSB, and where the very first byte starts
`define SAT_BYTE_MSB        3'h7
`define SAT_FIRST_BIT       3'h6
// Reset values of the pins
`define SAT_RST_BCLK        1'h0
`define SAT_RST_FS          1'h0
`define SAT_RST_SD          1'h0

`endif

// ### common/sat_pkg.sv
// Types shared by the stereo serial audio transmitter
package sat_pkg;

    // Controller states
    typedef enum logic {
        SAT_IDLE,
        SAT_RUN
    } sat_state_t;

    // Serial link pins toward the codec
    typedef struct packed {
        logic bit_clock;
        logic frame_select_out;
        logic serial_data;
    } sat_pins_t;

    // Byte offered by the sample source
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } sat_src_t;

    // Whole state of the transmitter
    typedef struct packed {
        sat_state_t state;
        logic [15:0] div;
        logic [5:0]  cnt;
        logic        first;
        logic [7:0]  shift;
        logic [2:0]  bit_idx;
        logic        underrun;
        sat_pins_t   pins;
    } sat_tx_state_t;

endpackage

// ### rtl/sat_top.sv
// Stereo serial audio transmitter with its byte FIFO
`timescale 1ns/100ps
`default_nettype none
`include "sat_consts.svh"

// Byte FIFO between the sample source and the shifter
// Registered ready and valid: neither side sees a combinational path
// through the other, at the cost of one cycle of fill latency.
// Full and empty come from a shared count, so the pointers never
// need an extra wrap bit.
// Read data is the word under the read pointer, valid with out_valid.
// Depth is a power of two so the pointers wrap without compare logic.
// Storage has no reset; the count alone says which words are live.
module sat_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `SAT_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             resetn,
    // Filling side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output var  logic             in_ready,
    // Draining side
    output var  logic [WIDTH-1:0] out_data,
    output var  logic             out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0]   count;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic          in_rdy;
        logic          out_vld;
    } sat_fifo_st_t;

    sat_fifo_st_t     st_ff;
    sat_fifo_st_t     nxt_st;
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic             push;
    logic             pop;

    // Pointers wrap for free only at a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("sat_fifo: DEPTH must be a power of two, at least 2");
    end

    // A zero-width word has nothing to carry
    if (WIDTH < 1) begin : g_bad_width
        $error("sat_fifo: WIDTH must be at least 1");
    end

    // Pointer advance, shared by both ends
    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = p + {{(AW-1){1'b0}}, 1'b1};
    endfunction

    assign push      = in_valid && st_ff.in_rdy;
    assign pop       = out_ready && st_ff.out_vld;
    assign in_ready  = st_ff.in_rdy;
    assign out_valid = st_ff.out_vld;
    assign out_data  = mem_ff[st_ff.rd];

    // Next state; flags are registered so both sides see clean levels
    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.wr = ptr_inc(st_ff.wr);
        end
        if (pop) begin
            nxt_st.rd = ptr_inc(st_ff.rd);
        end
        case ({push, pop})
            2'b10:   nxt_st.count = st_ff.count + 1'b1;
            2'b01:   nxt_st.count = st_ff.count - 1'b1;
            default: nxt_st.count = st_ff.count;
        endcase
        nxt_st.in_rdy  = (nxt_st.count != DEPTH[AW:0]);
        nxt_st.out_vld = (nxt_st.count != '0);
    end

    // State register
    always_ff @(posedge clock) begin
        if (!resetn) begin
            st_ff <= '{count: '0, wr: '0, rd: '0, in_rdy: 1'b1, out_vld: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Storage needs no reset; only written words are ever read
    always_ff @(posedge clock) begin
        if (push) begin
            mem_ff[st_ff.wr] <= in_data;
        end
    end
endmodule

// Serial transmitter: divider, frame counter and byte shifter.
// Limitations worth knowing before use:
// - The bit clock is a whole number of system clocks per half cell;
//   sample rates that do not divide evenly come out slightly fast.
// - The very first byte after start loses its top bit, so the first
//   left word carries 15 bits; every later word is complete.
// - An empty FIFO at a byte boundary sends a zero byte and pulses
//   underrun; the link keeps running so the codec stays locked.
// - Lowering enable stops only after the right word's last cell,
//   trading stop latency for never showing the codec a short frame.
// - A restart always begins again at the left word with a fresh drop.
// - Only byte-multiple word lengths are served, since the shifter
//   refills a whole byte at a time.
// - The source must keep up with one byte per eight cells; the FIFO
//   only hides bursts, not a slower average rate.
// - Enable is read on this clock; it must come from synchronous logic.

// Overview of operation
// - Each sample leaves the data line most significant bit first.
// - Channel word length is 16 bits, with 24 and 32 as options.
// - Data and frame select change on rising bit clock, or park low at a stop; codec samples falling.
// - Frame select low carries the left word, high the right word.
// - Frame select changes in the same bit cell as the word's first bit.
// - A subframe is 16 bits; frame select toggles on the following rise.
// - Frame counter wraps at 31, compares at 16, toggling at both.
// - The frame counter advances on rising bit clock edges.
// - Default frame: two 16-bit channels, 12 kHz, 32 bits, 384 kbit/s.
// - Each data bit is stable at the falling edge; clock idles low.
// - Once running, clock, frame select and data continue without gaps.
// - Start-up first left word has 15 bits; the first byte's MSB is dropped.
// - Bit clock comes from the system clock by integer division only.
module sat_top #(
    parameter int WORD_BITS  = `SAT_WORD_BITS,
    parameter int FIFO_DEPTH = `SAT_FIFO_DEPTH,
    parameter int HALF_DIV   = `SAT_HALF_DIV
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              resetn,
    // Control and status
    input  wire logic              enable,
    output var  logic              running,
    output var  logic              underrun,
    // Sample source, one byte per transfer
    input  wire sat_pkg::sat_src_t src,
    output var  logic              tx_holding_empty_flag,
    // Serial link to the codec
    output var  sat_pkg::sat_pins_t link
);
    // Counter modulus and compare point scale with the word length
    localparam logic [5:0]  COUNTER_MODULUS       = 6'(2 * WORD_BITS - 1);
    localparam logic [5:0]  CHANNEL_COMPARE_VALUE = 6'(WORD_BITS);
    localparam logic [15:0] DIV_LAST              = 16'(HALF_DIV - 1);

    // Link level while parked, after reset and after a stop
    localparam sat_pkg::sat_pins_t PINS_IDLE = '{
        bit_clock:        `SAT_RST_BCLK,
        frame_select_out: `SAT_RST_FS,
        serial_data:      `SAT_RST_SD
    };

    // Frame counter step; wraps after the last cell of the right word
    function automatic logic [5:0] frame_step(input logic [5:0] c);
        if (c == COUNTER_MODULUS) begin
            frame_step = 6'h0;
        end else begin
            frame_step = c + 6'h1;
        end
    endfunction

    // Side flips at the compare point and at reload only
    function automatic logic side_flip(input logic [5:0] c);
        side_flip = (c == CHANNEL_COMPARE_VALUE) || (c == 6'h0);
    endfunction

    // Half cell ends when the divider reads its last value
    function automatic logic half_end(input logic [15:0] d);
        half_end = (d == DIV_LAST);
    endfunction

    // Byte that the shifter takes: the FIFO head, or silence if starved
    function automatic logic [7:0] refill(input logic have, input logic [7:0] b);
        refill = have ? b : 8'h00;
    endfunction

    // State fields, all in one register:
    // - state: parked or running
    // - div: system clocks into the current half cell
    // - cnt: cell number within the frame, zero at the left word
    // - first: next rise is the start-up rise
    // - shift and bit_idx: byte on its way out and the bit to send next
    // - underrun: one-cycle flag for a starved refill
    // - pins: the three link outputs, registered

    sat_pkg::sat_tx_state_t st_ff;
    sat_pkg::sat_tx_state_t nxt_st;
    logic [7:0]             fifo_data;
    logic                   fifo_valid;
    logic                   pop;
    logic                   load;
    logic [2:0]             load_idx;
    logic                   half_done;
    logic                   frame_done;

    // Only byte-multiple word lengths the counter can hold
    if (WORD_BITS != 16 && WORD_BITS != 24 && WORD_BITS != 32) begin : g_bad_word
        $error("sat_top: WORD_BITS must be 16, 24 or 32");
    end
    if (HALF_DIV < 1 || HALF_DIV > 65536) begin : g_bad_div
        $error("sat_top: HALF_DIV out of range");
    end
    if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_fifo
        $error("sat_top: FIFO_DEPTH must be a power of two, at least 2");
    end

    // Holding stage; its room is the source's go-ahead
    // The flag is the FIFO's registered ready, so a full FIFO refuses
    // the next byte one cycle after the last free word is taken; the
    // source holds a refused byte and offers it again.
    sat_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .resetn    (resetn),
        .in_data   (src.data),
        .in_valid  (src.valid),
        .in_ready  (tx_holding_empty_flag),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (pop)
    );

    // Divider and frame strobes, shared by the run branches
    assign half_done  = half_end(st_ff.div);
    assign frame_done = (st_ff.cnt == COUNTER_MODULUS);

    // Cell timing, all in system clocks with H = HALF_DIV:
    // - a rise starts each cell, data and frame select move with it;
    // - the fall lands H clocks later, mid-cell, where the codec samples;
    // - the next rise lands H clocks after the fall.
    // The frame counter moves only on rises and at a stop, so frame select can never
    // change while the codec is sampling.
    // A byte is pulled on the rise that shifts out the previous byte's
    // last bit, which leaves the FIFO a whole byte time to refill.
    // The stop check sits on the low phase, so a stop never cuts a cell.
    // Next state of divider, frame counter and shifter
    always_comb begin
        nxt_st          = st_ff;
        nxt_st.underrun = 1'b0;
        pop             = 1'b0;
        load            = 1'b0;
        load_idx        = `SAT_BYTE_MSB;
        case (st_ff.state)
            sat_pkg::SAT_IDLE: begin
                if (enable) begin
                    nxt_st.state = sat_pkg::SAT_RUN;
                    nxt_st.div   = '0;
                    nxt_st.first = 1'b1;
                end
            end
            sat_pkg::SAT_RUN: begin
                if (!half_done) begin
                    nxt_st.div = st_ff.div + 16'h1;
                end else begin
                    nxt_st.div = '0;
                    if (st_ff.pins.bit_clock) begin
                        // Falling edge mid-cell; data held since the rise
                        nxt_st.pins.bit_clock = 1'b0;
                    end else if (!st_ff.first && !enable
                                 && frame_done) begin
                        // Stop only at a frame boundary so the codec never
                        // sees a partial frame
                        nxt_st.state            = sat_pkg::SAT_IDLE;
                        nxt_st.cnt              = '0;
                        nxt_st.pins             = PINS_IDLE;
                    end else if (st_ff.first) begin
                        // First rise: left channel, first byte loses its MSB
                        nxt_st.pins.bit_clock        = 1'b1;
                        nxt_st.first                 = 1'b0;
                        nxt_st.cnt                   = '0;
                        nxt_st.pins.frame_select_out = 1'b0;
                        nxt_st.pins.serial_data      = 1'b0;
                        load                         = 1'b1;
                        load_idx                     = `SAT_FIRST_BIT;
                    end else begin
                        // Every rise advances the frame and the data
                        nxt_st.pins.bit_clock = 1'b1;
                        nxt_st.cnt = frame_step(st_ff.cnt);
                        // Toggle at compare and reload, in the cell of the MSB
                        if (side_flip(nxt_st.cnt)) begin
                            nxt_st.pins.frame_select_out =
                                ~st_ff.pins.frame_select_out;
                        end
                        // Stream keeps step with frame select, moving in the same cell
                        nxt_st.pins.serial_data = st_ff.shift[st_ff.bit_idx];
                        if (st_ff.bit_idx == '0) begin
                            load = 1'b1;
                        end else begin
                            nxt_st.bit_idx = st_ff.bit_idx - 3'h1;
                        end
                    end
                end
            end
            default: begin
                nxt_st = '0;
            end
        endcase
        // Next byte in arrival order; zeros keep the frame going if starved
        if (load) begin
            nxt_st.bit_idx = load_idx;
            nxt_st.shift    = refill(fifo_valid, fifo_data);
            nxt_st.underrun = !fifo_valid;
            pop             = fifo_valid;
        end
    end

    // State register; reset parks the link with frame select low
    always_ff @(posedge clock) begin
        if (!resetn) begin
            st_ff       <= '0;
            st_ff.state <= sat_pkg::SAT_IDLE;
            st_ff.pins  <= PINS_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    // The state is a single flop, so running is that flop's value;
    // underrun and the link pins are fields of the same register, so
    // no output glitches while the next state settles.
    assign link     = st_ff.pins;
    assign underrun = st_ff.underrun;
    assign running  = (st_ff.state == sat_pkg::SAT_RUN);
endmodule

`default_nettype wire

// ### test/sat_codec_model.sv
// Behavioural codec capturing the serial link as a slave
`timescale 1ns/100ps
`default_nettype none
module sat_codec_model (
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               resetn,
    // Serial link from the transmitter
    input  wire sat_pkg::sat_pins_t link,
    // Captured bits, newest in bit 0
    output var  logic [31:0]        rx_data,
    output var  logic [31:0]        rx_side,
    output var  int                 falls
);
    logic bclk_ff;

    // Capture on falling edges only; a slave never drives the link
    always_ff @(posedge clock) begin
        bclk_ff <= link.bit_clock;
        if (!resetn) begin
            rx_data <= 32'h0;
            rx_side <= 32'h0;
            falls   <= 0;
        end else if (bclk_ff && !link.bit_clock) begin
            rx_data <= {rx_data[30:0], link.serial_data};
            rx_side <= {rx_side[30:0], link.frame_select_out};
            falls   <= falls + 1;
        end
    end
endmodule
`default_nettype wire

// ### test/sat_top_assertions.sv
// Port-level checks of the serial audio transmitter
`timescale 1ns/100ps
`default_nettype none
module sat_top_assertions #(
    parameter int WORD_BITS  = 16,
    parameter int FIFO_DEPTH = 16,
    parameter int HALF_DIV   = 2
) (
    // Clock and reset
    input wire logic               clock,
    input wire logic               resetn,
    // Control and status
    input wire logic               enable,
    input wire logic               running,
    input wire logic               underrun,
    input wire logic               tx_holding_empty_flag,
    // Serial link
    input wire sat_pkg::sat_pins_t link
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    logic [15:0] hcnt_ff;
    logic [7:0]  rcnt_ff;
    logic        bclk_ff;
    logic        fs_ff;
    logic        fell_ff;

    // Level run lengths; rise count per side, cleared while idle
    always_ff @(posedge clock) begin
        bclk_ff <= link.bit_clock;
        fs_ff   <= link.frame_select_out;
        hcnt_ff <= !resetn ? 16'h0 : (link.bit_clock != bclk_ff) ? 16'h1 : hcnt_ff + 16'h1;
        if (!resetn || !running) begin
            rcnt_ff <= 8'h0;
            fell_ff <= 1'b0;
        end else begin
            if (bclk_ff && !link.bit_clock)
                fell_ff <= 1'b1;
            if (link.frame_select_out != fs_ff)
                rcnt_ff <= 8'h1;
            else if (link.bit_clock && !bclk_ff)
                rcnt_ff <= rcnt_ff + 8'h1;
        end
    end

    // Stop path is excluded: enable low parks the pins at a frame end, off a rise
    sequence idle_enabled;
        !running && enable;
    endsequence
    sequence fs_toggle;
        enable && running && $past(running) && $changed(link.frame_select_out);
    endsequence

    chk_reset_quiet: assert property (disable iff (1'b0)
        !resetn |=> link == '0 && !running && !underrun && tx_holding_empty_flag)
        else $error("link or status not quiet after reset");
    chk_idle_quiet: assert property (
        !running && !$past(running) |-> link == '0)
        else $error("link active while idle");
    chk_high_time: assert property (
        running && $fell(link.bit_clock) |-> hcnt_ff == 16'(HALF_DIV))
        else $error("bit clock high phase wrong");
    chk_low_time: assert property (
        running && fell_ff && $rose(link.bit_clock) |-> hcnt_ff == 16'(HALF_DIV))
        else $error("bit clock low phase wrong");
    chk_data_on_rise: assert property (
        enable && running && $past(running) && $changed(link.serial_data)
        |-> $rose(link.bit_clock))
        else $error("data moved off a rising bit clock");
    chk_fs_on_rise: assert property (
        fs_toggle |-> $rose(link.bit_clock))
        else $error("frame select moved off a rising bit clock");
    chk_fs_spacing: assert property (
        fs_toggle |-> rcnt_ff == 8'(WORD_BITS))
        else $error("frame select side length wrong");
    chk_run_entry: assert property (
        idle_enabled |=> running)
        else $error("enable did not start the link");
    chk_run_holds: assert property (
        running && enable |=> running)
        else $error("link stopped while enabled");
    chk_underrun_pulse: assert property (
        underrun |=> !underrun)
        else $error("underrun longer than one cycle");
endmodule
`default_nettype wire

// ### test/sat_top_bench.sv
// Self-checking bench for the serial audio transmitter
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module sat_top_bench;
    logic               clock = 1'b0;
    logic               resetn = 1'b0;
    logic               enable = 1'b0;
    sat_pkg::sat_src_t  src = '0;
    logic               running;
    logic               underrun;
    logic               tx_holding_empty_flag;
    sat_pkg::sat_pins_t link;
    logic [31:0]        rx_data;
    logic [31:0]        rx_side;
    int                 falls;
    int                 sent = 0;
    int                 lim = 0;
    int                 errors = 0;
    int                 tests_run = 0;

    // Short half period keeps frames to 128 system cycles
    sat_top #(.HALF_DIV(2)) dut_u (.clock(clock), .resetn(resetn), .enable(enable),
        .running(running), .underrun(underrun), .src(src),
        .tx_holding_empty_flag(tx_holding_empty_flag), .link(link));
    sat_codec_model codec_u (.clock(clock), .resetn(resetn), .link(link),
        .rx_data(rx_data), .rx_side(rx_side), .falls(falls));

    // 100 MHz system clock
    always #5 clock = ~clock;

    function automatic logic [7:0] pat(input int i);
        return 8'(i * 37 + 91);
    endfunction

    // Source offers bytes in stream order and holds a refused one
    always @(posedge clock) begin
        if (src.valid && tx_holding_empty_flag)
            sent = sent + 1;
        src <= '{valid: sent < lim, data: pat(sent)};
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic wait_falls(input int n);
        int k = 0;
        while (falls < n && k < 5000) begin
            cyc(1);
            k++;
        end
        if (falls < n)
            errors++;
    endtask

    task automatic t_reset;
        `CHK(link, 3'h0)
        `CHK(running, 1'b0)
        `CHK(tx_holding_empty_flag, 1'b1)
    endtask

    // Fill while idle until the buffer refuses
    task automatic t_fill;
        lim = 17;
        cyc(24);
        `CHK(sent, 16)
        `CHK(tx_holding_empty_flag, 1'b0)
    endtask

    // First two frames as the codec sees them
    task automatic t_frames;
        logic [7:0]  b0;
        logic [31:0] exp;
        time         t0;
        lim = 400;
        @(posedge clock) enable <= 1'b1;
        wait_falls(32);
        t0 = $time;
        b0 = pat(0);
        exp = {1'b0, b0[6:0], pat(1), pat(2), pat(3)};
        `CHK(rx_data, exp)
        `CHK(rx_side, 32'h0000ffff)
        wait_falls(64);
        `CHK(int'($time - t0), 1280)
        exp = {pat(4), pat(5), pat(6), pat(7)};
        `CHK(rx_data, exp)
        `CHK(rx_side, 32'h0000ffff)
    endtask

    // Starved buffer sends zeros without stopping the link
    task automatic t_starve;
        int k = 0;
        lim = sent;
        while (underrun !== 1'b1 && k < 3000) begin
            cyc(1);
            k++;
        end
        `CHK(underrun, 1'b1)
        wait_falls(falls + 64);
        `CHK(rx_data, 32'h0)
        `CHK(running, 1'b1)
    endtask

    // Enable low ends the link at a frame boundary
    task automatic t_stop;
        int k = 0;
        int f;
        @(posedge clock) enable <= 1'b0;
        while (running !== 1'b0 && k < 300) begin
            cyc(1);
            k++;
        end
        `CHK(running, 1'b0)
        cyc(2);
        f = falls;
        `CHK(f % 32, 0)
        cyc(40);
        `CHK(falls, f)
        `CHK(link, 3'h0)
    endtask

    task automatic end_sim;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Main sequence after 20 cycles of reset
    initial begin
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        cyc(1);
        t_reset;
        t_fill;
        t_frames;
        t_starve;
        t_stop;
        end_sim;
    end

    // Watchdog well beyond the roughly 1250 cycles the tests need
    initial begin
        #200000;
        errors++;
        end_sim;
    end
endmodule

bind sat_top sat_top_assertions #(.WORD_BITS(WORD_BITS), .FIFO_DEPTH(FIFO_DEPTH),
    .HALF_DIV(HALF_DIV)) chk_u (.clock(clock), .resetn(resetn), .enable(enable),
    .running(running), .underrun(underrun),
    .tx_holding_empty_flag(tx_holding_empty_flag), .link(link));
`default_nettype wire
